//--- tef_defines.vh
`ifndef TEF_DEFINES_VH
`define TEF_DEFINES_VH

// ****************************************************
// Register offsets
// ****************************************************
`define TEF_OFS_OUT_SRC     8'h2d
`define TEF_OFS_IN_SRC      8'h2e
`define TEF_OFS_CFG         8'h2f
`define TEF_OFS_IRQ_STAT    8'h40
`define TEF_OFS_IRQ_MASK    8'h41

// ****************************************************
// Configuration field positions
// ****************************************************
`define TEF_CFG_OUT_LATCH   7
`define TEF_CFG_IN_LATCH    6
`define TEF_CFG_X_OUT_EN    5
`define TEF_CFG_Y_OUT_EN    4
`define TEF_CFG_Z_OUT_EN    3
`define TEF_CFG_X_IN_EN     2
`define TEF_CFG_Y_IN_EN     1
`define TEF_CFG_Z_IN_EN     0

// ****************************************************
// Source register field positions
// ****************************************************
`define TEF_SRC_ACTIVE      7
`define TEF_SRC_X_FLAG      5
`define TEF_SRC_Y_FLAG      3
`define TEF_SRC_Z_FLAG      1

// ****************************************************
// Interrupt status and mask bits
// ****************************************************
`define TEF_IRQ_IN_EVT      0
`define TEF_IRQ_OUT_EVT     1

// ****************************************************
// Reset values
// ****************************************************
`define TEF_CFG_RST_LOW     8'h00
`define TEF_CFG_RST_HIGH    8'h38
`define TEF_IRQ_MASK_RST    2'h0

// ****************************************************
// Timing: evaluation rate divider
// ****************************************************
`define TEF_CLK_HZ          250000000
`define TEF_ODR_HZ          100000
`define TEF_ODR_DIV         (`TEF_CLK_HZ / `TEF_ODR_HZ)
`define TEF_DIV_W           12

// ****************************************************
// Widths
// ****************************************************
`define TEF_DATA_W          12
`define TEF_DBC_W           8

`endif

//--- tef_dbnc.v
`timescale 1ns/1ps
`default_nettype none

`include "tef_defines.vh"

// Counts evaluations while the condition holds, saturating
module tef_dbnc
(
  input  wire                   mclk,
  input  wire                   arst_n,
  input  wire                   eval_en,
  input  wire                   cond,
  input  wire [`TEF_DBC_W-1:0]  limit,
  output wire                   reached
);

  reg  [`TEF_DBC_W-1:0] cnt_ff;
  wire [`TEF_DBC_W:0]   cnt_inc;

  assign cnt_inc = {1'b0, cnt_ff} + {{`TEF_DBC_W{1'b0}}, 1'b1};
  // Held for at least limit evaluations, this one included
  assign reached = cond && (cnt_inc >= {1'b0, limit});

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff <= {`TEF_DBC_W{1'b0}};
    end
    else if (eval_en)
    begin
      if (!cond)
      begin
        cnt_ff <= {`TEF_DBC_W{1'b0}};
      end
      else if (!(&cnt_ff))
      begin
        cnt_ff <= cnt_inc[`TEF_DBC_W-1:0];
      end
    end
  end

endmodule

`default_nettype wire

//--- tef_core.v
// What this block does
// [R1] Z inside flag: strictly between both thresholds
// [R2] Z inside flag valid only when enabled
// [R3] Inside latch: capture flags at event rise
// [R4] Host reads flags before inside source
// [R5] No latch: update when event active, debounced
// [R6] No latch, zero debounce: update every evaluation
// [R7] Config register at 2Fh, all read-write
// [R8] Strap high: outside enables reset to one
// [R9] Outside latch: cleared only by source read
// [R10] Outside latch: event only on false-to-true
// [R11] No outside latch: flags track in real time
// [R12] Inside latch: cleared only by source read
// [R13] Inside latch: event only on false-to-true
// [R14] No inside latch: flags track in real time
// [R15] X joins outside evaluation only when enabled
// [R16] Inside event after debounce count reached
// [R17] No inside axis enabled: function disabled
// [R18] Read returns pre-clear values, set wins
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "tef_defines.vh"

module tef_core
(
  input  wire                          mclk,
  input  wire                          arst_n,
  input  wire                          boot_mode_strap,
  input  wire signed [`TEF_DATA_W-1:0] x_data,
  input  wire signed [`TEF_DATA_W-1:0] y_data,
  input  wire signed [`TEF_DATA_W-1:0] z_data,
  input  wire signed [`TEF_DATA_W-1:0] upper_threshold,
  input  wire signed [`TEF_DATA_W-1:0] lower_threshold,
  input  wire [`TEF_DBC_W-1:0]         inside_debounce_count,
  input  wire [7:0]                    reg_addr,
  input  wire [7:0]                    reg_wdata,
  input  wire                          reg_wr,
  input  wire                          reg_rd,
  output reg  [7:0]                    reg_rdata_ff,
  output reg                           irq_ff,
  output reg                           inside_event_active_ff,
  output reg                           outside_event_active_ff,
  output reg                           odr_tick_ff
);

  // ****************************************************
  // Evaluation rate divider
  // ****************************************************
  localparam integer          DIV_LAST_I = `TEF_ODR_DIV - 1;
  localparam [`TEF_DIV_W-1:0] DIV_LAST   = DIV_LAST_I[`TEF_DIV_W-1:0];
  reg [`TEF_DIV_W-1:0] div_ff;
  wire                 eval_en;

  assign eval_en = (div_ff == DIV_LAST);

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_ff      <= {`TEF_DIV_W{1'b0}};
      odr_tick_ff <= 1'b0;
    end
    else
    begin
      div_ff      <= eval_en ? {`TEF_DIV_W{1'b0}} : div_ff + {{(`TEF_DIV_W-1){1'b0}}, 1'b1};
      odr_tick_ff <= eval_en;
    end
  end

  // ****************************************************
  // Configuration register and strap capture
  // ****************************************************
  reg  [7:0] cfg_ff;
  reg        init_done_ff;
  wire       wr_cfg;

  assign wr_cfg = reg_wr && (reg_addr == `TEF_OFS_CFG);

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_ff       <= `TEF_CFG_RST_LOW;
      init_done_ff <= 1'b0;
    end
    else if (!init_done_ff)
    begin
      init_done_ff <= 1'b1;
      cfg_ff       <= boot_mode_strap ? `TEF_CFG_RST_HIGH : `TEF_CFG_RST_LOW; // [R8]
    end
    else if (wr_cfg)
      cfg_ff <= reg_wdata; // [R7]
  end

  wire       in_latch;
  wire       out_latch;
  wire [2:0] in_en;
  wire [2:0] out_en;

  assign in_latch  = cfg_ff[`TEF_CFG_IN_LATCH];
  assign out_latch = cfg_ff[`TEF_CFG_OUT_LATCH];
  assign in_en     = {cfg_ff[`TEF_CFG_X_IN_EN], cfg_ff[`TEF_CFG_Y_IN_EN],
                      cfg_ff[`TEF_CFG_Z_IN_EN]};
  assign out_en    = {cfg_ff[`TEF_CFG_X_OUT_EN], cfg_ff[`TEF_CFG_Y_OUT_EN],
                      cfg_ff[`TEF_CFG_Z_OUT_EN]};

  // ****************************************************
  // Per-axis window comparators, index 2 = X, 0 = Z
  // ****************************************************
  wire [3*`TEF_DATA_W-1:0] axis_bus;
  wire [2:0]               in_raw;
  wire [2:0]               out_raw;

  assign axis_bus = {x_data, y_data, z_data};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_axis
      wire signed [`TEF_DATA_W-1:0] d;
      assign d = axis_bus[gi*`TEF_DATA_W +: `TEF_DATA_W];
      // Strictly inside both thresholds, gated by participation
      assign in_raw[gi]  = in_en[gi] && (d < upper_threshold)
                           && (d > lower_threshold); // [R1] [R2]
      assign out_raw[gi] = out_en[gi] && ((d >= upper_threshold)
                           || (d <= lower_threshold)); // [R15]
    end
  endgenerate

  wire in_cond;
  wire out_cond;
  wire in_reached;
  assign in_cond  = (|in_en) && (|in_raw); // [R17]
  assign out_cond = |out_raw;

  tef_dbnc u_in_dbnc
  (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .eval_en (eval_en),
    .cond    (in_cond),
    .limit   (inside_debounce_count),
    .reached (in_reached)
  );

  // ****************************************************
  // Register reads and read-to-clear
  // ****************************************************
  reg  [2:0] in_flags_ff;
  reg  [2:0] out_flags_ff;
  reg        in_armed_ff;
  reg        out_armed_ff;
  reg  [1:0] irq_stat_ff;
  reg  [1:0] irq_mask_ff;
  wire       rd_in_src;
  wire       rd_out_src;

  assign rd_in_src  = reg_rd && (reg_addr == `TEF_OFS_IN_SRC);
  assign rd_out_src = reg_rd && (reg_addr == `TEF_OFS_OUT_SRC);

  reg [7:0] rd_mux;
  always @*
  begin
    rd_mux = 8'h00;
    case (reg_addr)
      `TEF_OFS_IN_SRC:
      begin
        rd_mux[`TEF_SRC_ACTIVE] = inside_event_active_ff;
        rd_mux[`TEF_SRC_X_FLAG] = in_flags_ff[2];
        rd_mux[`TEF_SRC_Y_FLAG] = in_flags_ff[1];
        rd_mux[`TEF_SRC_Z_FLAG] = in_flags_ff[0];
      end
      `TEF_OFS_OUT_SRC:
      begin
        rd_mux[`TEF_SRC_ACTIVE] = outside_event_active_ff;
        rd_mux[`TEF_SRC_X_FLAG] = out_flags_ff[2];
        rd_mux[`TEF_SRC_Y_FLAG] = out_flags_ff[1];
        rd_mux[`TEF_SRC_Z_FLAG] = out_flags_ff[0];
      end
      `TEF_OFS_CFG:      rd_mux = cfg_ff;
      `TEF_OFS_IRQ_STAT: rd_mux = {6'h00, irq_stat_ff};
      `TEF_OFS_IRQ_MASK: rd_mux = {6'h00, irq_mask_ff};
      default:           rd_mux = 8'h00;
    endcase
  end

  // Data captured from pre-clear state in the read cycle
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_ff <= 8'h00;
    else
      reg_rdata_ff <= reg_rd ? rd_mux : 8'h00; // [R18]
  end

  // ****************************************************
  // Inside-window event and flags
  // ****************************************************
  reg [2:0] nxt_in_flags;
  reg       nxt_in_active;
  reg       nxt_in_armed;
  reg       in_evt;

  always @*
  begin
    nxt_in_flags  = in_flags_ff;
    nxt_in_active = inside_event_active_ff;
    nxt_in_armed  = in_armed_ff;
    in_evt        = 1'b0;
    if (in_latch)
    begin
      // Clear first so a same-cycle event still sets
      if (rd_in_src)
      begin
        nxt_in_flags  = 3'h0; // [R12] [R18]
        nxt_in_active = 1'b0;
      end
      if (eval_en)
      begin
        if (!in_cond)
          nxt_in_armed = 1'b1;
        else if (in_reached && in_armed_ff)
        begin
          nxt_in_active = 1'b1; // [R13] [R16]
          nxt_in_flags  = nxt_in_flags | in_raw; // [R3]
          nxt_in_armed  = 1'b0;
          in_evt        = 1'b1;
        end
      end
    end
    else if (eval_en)
    begin
      nxt_in_armed  = 1'b1;
      nxt_in_active = in_reached; // [R16]
      in_evt        = in_reached && !inside_event_active_ff;
      if ((inside_debounce_count == {`TEF_DBC_W{1'b0}}) || in_reached)
        nxt_in_flags = in_raw; // [R5] [R6]
      else if (!in_cond)
        nxt_in_flags = 3'h0; // [R14]
    end
  end

  // ****************************************************
  // Outside-window event and flags
  // ****************************************************
  reg [2:0] nxt_out_flags;
  reg       nxt_out_active;
  reg       nxt_out_armed;
  reg       out_evt;

  always @*
  begin
    nxt_out_flags  = out_flags_ff;
    nxt_out_active = outside_event_active_ff;
    nxt_out_armed  = out_armed_ff;
    out_evt        = 1'b0;
    if (out_latch)
    begin
      if (rd_out_src)
      begin
        nxt_out_flags  = 3'h0; // [R9] [R18]
        nxt_out_active = 1'b0;
      end
      if (eval_en)
      begin
        if (!out_cond)
          nxt_out_armed = 1'b1;
        else if (out_armed_ff)
        begin
          nxt_out_active = 1'b1; // [R10]
          nxt_out_flags  = nxt_out_flags | out_raw;
          nxt_out_armed  = 1'b0;
          out_evt        = 1'b1;
        end
      end
    end
    else if (eval_en)
    begin
      nxt_out_armed  = 1'b1;
      nxt_out_flags  = out_raw; // [R11]
      nxt_out_active = out_cond;
      out_evt        = out_cond && !outside_event_active_ff;
    end
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_flags_ff             <= 3'h0;
      out_flags_ff            <= 3'h0;
      in_armed_ff             <= 1'b1;
      out_armed_ff            <= 1'b1;
      inside_event_active_ff  <= 1'b0;
      outside_event_active_ff <= 1'b0;
    end
    else
    begin
      in_flags_ff             <= nxt_in_flags;
      out_flags_ff            <= nxt_out_flags;
      in_armed_ff             <= nxt_in_armed;
      out_armed_ff            <= nxt_out_armed;
      inside_event_active_ff  <= nxt_in_active;
      outside_event_active_ff <= nxt_out_active;
    end
  end

  // ****************************************************
  // Interrupt status, mask and output
  // ****************************************************
  wire [1:0] evt_vec;
  wire [1:0] stat_clr;
  wire [1:0] nxt_irq_stat;
  assign evt_vec      = {out_evt, in_evt};
  assign stat_clr     = (reg_wr && (reg_addr == `TEF_OFS_IRQ_STAT)) ? reg_wdata[1:0] : 2'h0;
  assign nxt_irq_stat = (irq_stat_ff & ~stat_clr) | evt_vec;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_stat_ff <= 2'h0;
      irq_mask_ff <= `TEF_IRQ_MASK_RST;
      irq_ff      <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      if (reg_wr && (reg_addr == `TEF_OFS_IRQ_MASK))
        irq_mask_ff <= reg_wdata[1:0];
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

endmodule

`default_nettype wire

//--- tef_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checks
// ********
module tef_sva
(
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic       irq_ff,
  input wire logic       inside_event_active_ff,
  input wire logic       outside_event_active_ff,
  input wire logic       odr_tick_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
    else $error("read data outside answer cycle");
  AST_CFG_RB: assert property ((reg_wr && reg_addr == 8'h2f ##2 reg_rd && reg_addr == 8'h2f)
    |=> reg_rdata_ff == $past(reg_wdata, 3))
    else $error("config readback differs");
  AST_IN_RISE: assert property ($rose(inside_event_active_ff) |-> ##[0:1] odr_tick_ff)
    else $error("inside event rose off evaluation");
  AST_OUT_RISE: assert property ($rose(outside_event_active_ff) |-> ##[0:1] odr_tick_ff)
    else $error("outside event rose off evaluation");
  AST_IN_FALL: assert property ($fell(inside_event_active_ff) |-> odr_tick_ff
    || $past(odr_tick_ff) || $past(reg_rd) || $past(reg_rd, 2))
    else $error("inside event fell without cause");
  AST_OUT_FALL: assert property ($fell(outside_event_active_ff) |-> odr_tick_ff
    || $past(odr_tick_ff) || $past(reg_rd) || $past(reg_rd, 2))
    else $error("outside event fell without cause");
  AST_IRQ_FALL: assert property ($fell(irq_ff) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt fell without a write");
  AST_TICK_GAP: assert property (odr_tick_ff |=> !odr_tick_ff [*8])
    else $error("evaluations too close");
endmodule
`default_nettype wire

//--- tef_host.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Host processor on the register port
// ********
module tef_host
(
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata_ff,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Flags are taken from the same read that clears them
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask
endmodule
`default_nettype wire

//--- threshold_event_flag_latch_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tef_defines.vh"
// ********
// Bench
// ********
module threshold_event_flag_latch_bench;
  logic               mclk = 1'b0;
  logic               arst_n = 1'b0;
  logic               boot_mode_strap = 1'b0;
  logic signed [11:0] x_data = 12'h000;
  logic signed [11:0] y_data = 12'h000;
  logic signed [11:0] z_data = 12'h000;
  logic signed [11:0] upper_threshold = 12'h064;
  logic signed [11:0] lower_threshold = 12'hf9c;
  logic [7:0]         inside_debounce_count = 8'h00;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata_ff;
  logic               reg_wr, reg_rd, irq_ff, odr_tick_ff;
  logic               inside_event_active_ff, outside_event_active_ff;
  logic [11:0]        zv [4] = '{12'h032, 12'h064, 12'h063, 12'hf9c};
  logic [7:0]         ex [4] = '{8'h02, 8'h00, 8'h02, 8'h00};
  int                 err_count = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  always #2 mclk = ~mclk;
  tef_host i_host (.mclk, .reg_rdata_ff, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  tef_core i_dut (.mclk, .arst_n, .boot_mode_strap, .x_data, .y_data, .z_data,
    .upper_threshold, .lower_threshold, .inside_debounce_count, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata_ff, .irq_ff, .inside_event_active_ff,
    .outside_event_active_ff, .odr_tick_ff);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk($sformatf("reg %h", a), e, d & m);
  endtask
  task automatic ev(input int n);
    repeat (2) @(posedge mclk);
    repeat (n) @(posedge odr_tick_ff);
    @(negedge mclk);
  endtask
  task automatic sd(input logic [11:0] x, input logic [11:0] z);
    @(posedge mclk);
    x_data <= x;
    z_data <= z;
  endtask
  // Samples the named output after it has settled, not at call time
  task automatic bitc(input string nm, input logic e);
    logic g;
    repeat (2) @(posedge mclk);
    #1 g = (nm == "irq") ? irq_ff :
           (nm == "outside active") ? outside_event_active_ff : inside_event_active_ff;
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rst(input logic s);
    @(posedge mclk);
    arst_n <= 1'b0;
    boot_mode_strap <= s;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_cfg;
    rst(1'b0);
    rdc(`TEF_OFS_CFG, 8'hff, 8'h00);
    rdc(8'h10, 8'hff, 8'h00);
    i_host.wr(`TEF_OFS_CFG, 8'hff);
    rdc(`TEF_OFS_CFG, 8'hff, 8'hff);
    i_host.wr(`TEF_OFS_CFG, 8'h5a);
    rdc(`TEF_OFS_CFG, 8'hff, 8'h5a);
    rst(1'b1);
    rdc(`TEF_OFS_CFG, 8'hff, 8'h38);
    i_host.wr(`TEF_OFS_IN_SRC, 8'hff);
    rdc(`TEF_OFS_IN_SRC, 8'hff, 8'h00);
    $display("config test done");
  endtask
  task automatic t_live;
    i_host.wr(`TEF_OFS_CFG, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      sd(12'h000, zv[i]);
      ev(1);
      rdc(`TEF_OFS_IN_SRC, 8'h02, ex[i]);
    end
    $display("live inside test done");
  endtask
  task automatic t_latch;
    i_host.wr(`TEF_OFS_CFG, 8'h41);
    sd(12'h000, 12'h0c8);
    ev(1);
    rdc(`TEF_OFS_IN_SRC, 8'h82, 8'h00);
    sd(12'h000, 12'h032);
    ev(2);
    rdc(`TEF_OFS_IN_SRC, 8'h82, 8'h82);
    ev(1);
    rdc(`TEF_OFS_IN_SRC, 8'h82, 8'h00);
    sd(12'h000, 12'h032);
    sd(12'h000, 12'h0c8);
    ev(1);
    rdc(`TEF_OFS_IN_SRC, 8'h82, 8'h00);
    sd(12'h000, 12'h032);
    ev(1);
    sd(12'h000, 12'h0c8);
    ev(1);
    rdc(`TEF_OFS_IN_SRC, 8'h82, 8'h82);
    bitc("irq", 1'b0);
    i_host.wr(`TEF_OFS_IRQ_MASK, 8'h01);
    bitc("irq", 1'b1);
    rdc(`TEF_OFS_IRQ_STAT, 8'h03, 8'h01);
    i_host.wr(`TEF_OFS_IRQ_STAT, 8'h03);
    bitc("irq", 1'b0);
    rdc(`TEF_OFS_IRQ_STAT, 8'h03, 8'h00);
    $display("latched inside test done");
  endtask
  task automatic t_dbc;
    i_host.wr(`TEF_OFS_CFG, 8'h01);
    inside_debounce_count <= 8'h02;
    ev(1);
    sd(12'h000, 12'h032);
    ev(1);
    bitc("inside active", 1'b0);
    rdc(`TEF_OFS_IN_SRC, 8'h02, 8'h00);
    ev(2);
    bitc("inside active", 1'b1);
    rdc(`TEF_OFS_IN_SRC, 8'h82, 8'h82);
    @(posedge mclk);
    inside_debounce_count <= 8'h00;
    i_host.wr(`TEF_OFS_CFG, 8'h00);
    ev(1);
    bitc("inside active", 1'b0);
    $display("debounce test done");
  endtask
  task automatic t_out;
    i_host.wr(`TEF_OFS_CFG, 8'h20);
    sd(12'h0c8, 12'h000);
    ev(1);
    rdc(`TEF_OFS_OUT_SRC, 8'h20, 8'h20);
    i_host.wr(`TEF_OFS_CFG, 8'h10);
    ev(1);
    rdc(`TEF_OFS_OUT_SRC, 8'h20, 8'h00);
    i_host.wr(`TEF_OFS_CFG, 8'ha0);
    ev(1);
    sd(12'h000, 12'h000);
    ev(1);
    bitc("outside active", 1'b1);
    rdc(`TEF_OFS_OUT_SRC, 8'ha0, 8'ha0);
    bitc("outside active", 1'b0);
    rdc(`TEF_OFS_OUT_SRC, 8'ha0, 8'h00);
    i_host.wr(`TEF_OFS_CFG, 8'h20);
    sd(12'h0c8, 12'h000);
    ev(1);
    sd(12'h000, 12'h000);
    ev(1);
    rdc(`TEF_OFS_OUT_SRC, 8'h20, 8'h00);
    $display("outside test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    t_cfg();
    t_live();
    t_latch();
    t_dbc();
    t_out();
    conclude();
  end
endmodule
bind tef_core tef_sva i_sva (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_ff, .irq_ff, .inside_event_active_ff, .outside_event_active_ff, .odr_tick_ff);
`default_nettype wire
